// >>> rtl/compact_timer_regs.svh
/*
  Offsets, fields, reset values and codes of the compact timer.
  Assumes inclusion by bare name from the timer sources; definitions only.
*/
`ifndef COMPACT_TIMER_REGS_SVH
`define COMPACT_TIMER_REGS_SVH

// Byte addresses of the registers.
`define CT_ADDR_W        8
`define CT_OFF_CTRL0     8'h00
`define CT_OFF_CTRL1     8'h04
`define CT_OFF_CNT_LO    8'h08
`define CT_OFF_CNT_HI    8'h0c
`define CT_OFF_CMPA_LO   8'h10
`define CT_OFF_CMPA_HI   8'h14
`define CT_OFF_STATUS    8'h18

// Control register reset values.
`define CT_CTRL0_RST     8'h00
`define CT_CTRL1_RST     8'h00

// Status bits; a written one clears the flag.
`define CT_STAT_A_BIT    0
`define CT_STAT_P_BIT    1

// Clock source select codes.
`define CT_CK_SYS4       3'h0
`define CT_CK_SYS        3'h1
`define CT_CK_HI16       3'h2
`define CT_CK_HI64       3'h3
`define CT_CK_SUB0       3'h4
`define CT_CK_SUB1       3'h5
`define CT_CK_EXT_RISE   3'h6
`define CT_CK_EXT_FALL   3'h7

// Divider ratios.
`define CT_DIV_SYS       4
`define CT_DIV_HI16      16
`define CT_DIV_HI64      64

// Output function codes.
`define CT_IO_NONE       2'h0
`define CT_IO_LOW        2'h1
`define CT_IO_HIGH       2'h2
`define CT_IO_TOGGLE     2'h3

// Bus responses.
`define CT_RESP_OKAY     2'h0
`define CT_RESP_SLVERR   2'h2

`endif

// >>> rtl/compact_timer_pkg.sv
/*
  Compact timer types: control layouts and modes.
  Assumes nothing.
*/
package compact_timer_pkg;

  // Modes; undefined 2'b01 acts as timer mode.
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF   = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } mode_t;

  // First control register, bit 7 down to bit 0.
  typedef struct packed {
    logic       counter_pause;
    logic [2:0] clock_source_select;
    logic       counter_run_enable;
    logic [2:0] period_compare_value;
  } ctrl0_t;

  // Second control register, bit 7 down to bit 0.
  typedef struct packed {
    mode_t      mode;
    logic [1:0] out_func;
    logic       out_init;
    logic       out_invert;
    logic       duty_swap;
    logic       counter_clear_select;
  } ctrl1_t;

endpackage

// >>> rtl/edge_sync.sv
/*
  Two-stage synchroniser with edge detection.
  Assumes an asynchronous input and one clock.
*/
`timescale 1ns/1ps

module edge_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic meta_q;  // First stage, read only by the second.
  logic sync_q;  // Second stage, safe to use.
  logic prev_q;  // Delayed copy for edge detection.

  // Synchronise, then register the edges.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
      rise   <= sync_q & ~prev_q;
      fall   <= ~sync_q & prev_q;
    end
  end

endmodule

// >>> rtl/tick_divider.sv
/*
  Divides a stream of one-cycle ticks by DIV, giving a registered one-cycle tick.
  Assumes in_tick is synchronous to ref_clk.
*/
`timescale 1ns/1ps

module tick_divider #(
  parameter int DIV = 4
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic in_tick,
  output logic      out_tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  if (DIV < 2)
  begin : g_bad_div
    $error("tick_divider needs DIV of at least 2");
  end

  logic [CW-1:0] cnt_q;  // Input ticks seen in this output period.

  // One output tick per DIV input ticks.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_q    <= '0;
      out_tick <= 1'b0;
    end
    else
    begin
      out_tick <= in_tick && (cnt_q == CW'(DIV - 1));
      if (in_tick)
      begin
        cnt_q <= (cnt_q == CW'(DIV - 1)) ? '0 : cnt_q + CW'(1);
      end
    end
  end

endmodule

// >>> rtl/compact_timer.sv
/*
  Compact timer: 10-bit counter, two comparators, output pin,
  PWM, byte buffer, sticky flags, AXI4-Lite slave.
  Assumes high_clk_tick and sub_clk_tick are one-cycle
  ref_clk enables; the external pin may be asynchronous.
*/
// Implementation choices: the register addresses and the AXI4-Lite slave port.
// Function
// - Counter clock picked by 3-bit select.
// - External pin counts on chosen edge.
// - Separate A-match and period-match events.
// - Compare match sets, clears or toggles pin.
// - PWM appears on the same output pin.
// - Low byte write goes to holding buffer.
// - High byte write also copies buffer low.
// - High byte read captures low into buffer.
// - Low byte read returns holding buffer.
// - Ten-bit counter counting only upward.
// - Period value meets counter top three bits.
// - Compare A meets all ten counter bits.
// - Software clears counter only by run rising edge.
// - Overflow or selected match clears counter.
// - Compare, timer and PWM modes supported.
// - Select codes map to documented sources.
// - Period code times 128; zero overflows.
// - Clear select picks period or A match; PWM uses swap bit.
// - Pause holds count; resume from there.
`timescale 1ns/1ps
`include "compact_timer_regs.svh"

module compact_timer (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [`CT_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`CT_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   ext_count_clock_pin,
  input  wire logic                   high_clk_tick,
  input  wire logic                   sub_clk_tick,
  output logic                        timer_output_pin,
  output logic                        match_a_pulse,
  output logic                        match_p_pulse,
  output logic                        match_a_flag,
  output logic                        match_p_flag
);

  // Control state.
  compact_timer_pkg::ctrl0_t ctrl0_q;     // Pause, clock select, run, period.
  compact_timer_pkg::ctrl1_t ctrl1_q;     // Mode, output function, clear select.
  logic [9:0]                cmpa_q;      // Comparator A value.
  logic [7:0]                hold_q;      // Shared low byte holding buffer.
  logic                      run_prev_q;  // Run enable one cycle ago.

  // Counter and output state.
  logic [9:0]                cnt_q;       // The main counter.
  logic [9:0]                cnt_nxt;     // Counter plus one, wrapping.
  logic                      out_q;       // Compare mode output level.

  // Clock enables.
  logic                      tick_sys4;
  logic                      tick_hi16;
  logic                      tick_hi64;
  logic                      ext_rise;
  logic                      ext_fall;
  logic                      sel_tick;    // Enable of the chosen source.
  logic                      count_en;    // Counter steps this cycle.
  logic                      start;       // Run enable has just risen.

  // Comparator results.
  logic                      hit_a;
  logic                      hit_p;
  logic                      clear_by_a;
  logic                      cnt_clear;
  logic [9:0]                duty_val;
  logic                      pwm_active;
  logic                      pin_d;

  // Bus state.
  logic                      aw_full_q;
  logic [`CT_ADDR_W-1:0]     awaddr_q;
  logic                      w_full_q;
  logic [31:0]               wdata_q;
  logic [3:0]                wstrb_q;
  logic                      do_wr;
  logic                      wr_en;
  logic                      wr_mapped;
  logic                      rd_take;
  logic                      rd_mapped;
  logic [31:0]               rd_word;

  // Edge detection on the synchronised external pin.
  edge_sync u_ext_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (ext_count_clock_pin),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  // System clock divided by four.
  tick_divider #(.DIV(`CT_DIV_SYS)) u_div_sys4 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .in_tick  (1'b1),
    .out_tick (tick_sys4)
  );

  // High clock divided by sixteen.
  tick_divider #(.DIV(`CT_DIV_HI16)) u_div_hi16 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .in_tick  (high_clk_tick),
    .out_tick (tick_hi16)
  );

  // High clock divided by sixty-four.
  tick_divider #(.DIV(`CT_DIV_HI64)) u_div_hi64 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .in_tick  (high_clk_tick),
    .out_tick (tick_hi64)
  );

  // Pick the counter clock enable.
  always_comb
  begin
    case (ctrl0_q.clock_source_select)
      `CT_CK_SYS4:     sel_tick = tick_sys4;
      `CT_CK_SYS:      sel_tick = 1'b1;
      `CT_CK_HI16:     sel_tick = tick_hi16;
      `CT_CK_HI64:     sel_tick = tick_hi64;
      `CT_CK_SUB0:     sel_tick = sub_clk_tick;
      `CT_CK_SUB1:     sel_tick = sub_clk_tick;
      `CT_CK_EXT_RISE: sel_tick = ext_rise;
      `CT_CK_EXT_FALL: sel_tick = ext_fall;
      default:         sel_tick = 1'b0;
    endcase
  end

  // Pause gates the enable so the count is simply held.
  assign count_en = ctrl0_q.counter_run_enable & ~ctrl0_q.counter_pause & sel_tick;
  assign start    = ctrl0_q.counter_run_enable & ~run_prev_q;
  assign cnt_nxt  = cnt_q + 10'h001;

  // Matches are judged on the value the counter is about to take.
  always_comb
  begin
    if (ctrl0_q.period_compare_value == 3'h0)
    begin
      hit_p = count_en & (cnt_nxt == 10'h000);
    end
    else
    begin
      hit_p = count_en & (cnt_nxt[9:7] == ctrl0_q.period_compare_value)
                       & (cnt_nxt[6:0] == 7'h00);
    end
  end

  assign hit_a = count_en & (cnt_nxt == cmpa_q);

  // In PWM the period comparator is whichever the swap bit names.
  assign clear_by_a = (ctrl1_q.mode == compact_timer_pkg::MODE_PWM) ?
                      ctrl1_q.duty_swap : ctrl1_q.counter_clear_select;
  assign cnt_clear  = clear_by_a ? hit_a : hit_p;

  // Track run enable for its rising edge.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      run_prev_q <= 1'b0;
    end
    else
    begin
      run_prev_q <= ctrl0_q.counter_run_enable;
    end
  end

  // The counter; software cannot load it, only restart it.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_q <= 10'h000;
    end
    else if (start)
    begin
      cnt_q <= 10'h000;
    end
    else if (cnt_clear)
    begin
      cnt_q <= 10'h000;
    end
    else if (count_en)
    begin
      cnt_q <= cnt_nxt;  // Natural wrap at 1023 is the overflow.
    end
  end

  // Compare mode output level; restart returns it to its initial value.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      out_q <= 1'b0;
    end
    else if (start)
    begin
      out_q <= ctrl1_q.out_init;
    end
    else if (hit_a && ctrl1_q.mode == compact_timer_pkg::MODE_COMPARE)
    begin
      case (ctrl1_q.out_func)
        `CT_IO_LOW:    out_q <= 1'b0;
        `CT_IO_HIGH:   out_q <= 1'b1;
        `CT_IO_TOGGLE: out_q <= ~out_q;
        default:       out_q <= out_q;
      endcase
    end
  end

  // PWM duty is comparator A, or the period code when swapped.
  assign duty_val   = ctrl1_q.duty_swap ?
                      {ctrl0_q.period_compare_value, 7'h00} : cmpa_q;
  assign pwm_active = cnt_q < duty_val;

  // Form the pin level for the mode in force.
  always_comb
  begin
    case (ctrl1_q.mode)
      compact_timer_pkg::MODE_COMPARE:
      begin
        pin_d = out_q ^ ctrl1_q.out_invert;
      end
      compact_timer_pkg::MODE_PWM:
      begin
        case (ctrl1_q.out_func)
          `CT_IO_LOW:  pin_d = ctrl1_q.out_init;
          `CT_IO_HIGH: pin_d = pwm_active ? ctrl1_q.out_init : ~ctrl1_q.out_init;
          default:     pin_d = ~ctrl1_q.out_init;
        endcase
        pin_d = pin_d ^ ctrl1_q.out_invert;
      end
      default:
      begin
        pin_d = out_q;  // Timer mode leaves the pin alone.
      end
    endcase
  end

  // Register the pin and the event pulses.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      timer_output_pin <= 1'b0;
      match_a_pulse    <= 1'b0;
      match_p_pulse    <= 1'b0;
    end
    else
    begin
      timer_output_pin <= pin_d;
      match_a_pulse    <= hit_a;
      match_p_pulse    <= hit_p;
    end
  end

  // Sticky flags; a new event in the clearing cycle wins.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end
    else
    begin
      match_a_flag <= hit_a | (match_a_flag & ~(wr_en && awaddr_q == `CT_OFF_STATUS
                      && wdata_q[`CT_STAT_A_BIT]));
      match_p_flag <= hit_p | (match_p_flag & ~(wr_en && awaddr_q == `CT_OFF_STATUS
                      && wdata_q[`CT_STAT_P_BIT]));
    end
  end

  // Address and data are caught separately, in either order.
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready  = ~w_full_q;
  assign do_wr         = aw_full_q & w_full_q & ~s_axi_bvalid;
  // Only byte lane 0 carries register data.
  assign wr_en         = do_wr & wstrb_q[0];

  always_comb
  begin
    case (awaddr_q)
      `CT_OFF_CTRL0, `CT_OFF_CTRL1, `CT_OFF_CNT_LO, `CT_OFF_CNT_HI,
      `CT_OFF_CMPA_LO, `CT_OFF_CMPA_HI, `CT_OFF_STATUS: wr_mapped = 1'b1;
      default:                                         wr_mapped = 1'b0;
    endcase
  end

  // Write channel holding and response.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aw_full_q    <= 1'b0;
      awaddr_q     <= '0;
      w_full_q     <= 1'b0;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (do_wr)
      begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (do_wr)
      begin
        w_full_q <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `CT_RESP_OKAY : `CT_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control and compare registers; counter is read only.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl0_q <= compact_timer_pkg::ctrl0_t'(`CT_CTRL0_RST);
      ctrl1_q <= compact_timer_pkg::ctrl1_t'(`CT_CTRL1_RST);
      cmpa_q  <= 10'h000;
    end
    else if (wr_en)
    begin
      case (awaddr_q)
        `CT_OFF_CTRL0:   ctrl0_q <= compact_timer_pkg::ctrl0_t'(wdata_q[7:0]);
        `CT_OFF_CTRL1:   ctrl1_q <= compact_timer_pkg::ctrl1_t'(wdata_q[7:0]);
        `CT_OFF_CMPA_HI: cmpa_q  <= {wdata_q[1:0], hold_q};
        default:         cmpa_q  <= cmpa_q;
      endcase
    end
  end

  // One read at a time, answered one cycle after it is taken.
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take       = s_axi_arvalid & ~s_axi_rvalid;

  always_comb
  begin
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      `CT_OFF_CTRL0:   rd_word = {24'h0, ctrl0_q};
      `CT_OFF_CTRL1:   rd_word = {24'h0, ctrl1_q};
      `CT_OFF_CNT_LO:  rd_word = {24'h0, hold_q};
      `CT_OFF_CNT_HI:  rd_word = {30'h0, cnt_q[9:8]};
      `CT_OFF_CMPA_LO: rd_word = {24'h0, hold_q};
      `CT_OFF_CMPA_HI: rd_word = {30'h0, cmpa_q[9:8]};
      `CT_OFF_STATUS:  rd_word = {30'h0, match_p_flag, match_a_flag};
      default:
      begin
        rd_word   = 32'h0;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `CT_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_mapped ? `CT_RESP_OKAY : `CT_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Holding buffer; software keeps the access order itself.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hold_q <= 8'h00;
    end
    else if (wr_en && awaddr_q == `CT_OFF_CMPA_LO)
    begin
      hold_q <= wdata_q[7:0];
    end
    else if (rd_take && s_axi_araddr == `CT_OFF_CNT_HI)
    begin
      hold_q <= cnt_q[7:0];
    end
    else if (rd_take && s_axi_araddr == `CT_OFF_CMPA_HI)
    begin
      hold_q <= cmpa_q[7:0];
    end
  end

endmodule

// >>> tb/compact_timer_asserts.sv
/*
  Port checker of the compact timer.
  Assumes a bind to the timer; sees its ports only.
*/
`timescale 1ns/1ps

module compact_timer_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        match_a_pulse,
  input wire logic        match_p_pulse,
  input wire logic        match_a_flag,
  input wire logic        match_p_flag
);
  // Cycles since the last period event, saturating.
  logic [10:0] p_gap_q;

  // Restart at each period event.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      p_gap_q <= 11'h7ff;
    else if (match_p_pulse)
      p_gap_q <= 11'h000;
    else if (p_gap_q != 11'h7ff)
      p_gap_q <= p_gap_q + 11'h001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_a_flag_set: assert property (match_a_pulse |-> ##[0:1] match_a_flag)
    else $error("A flag not set");
  a_p_flag_set: assert property (match_p_pulse |-> ##[0:1] match_p_flag)
    else $error("period flag not set");
  a_a_pulse_single: assert property (match_a_pulse |=> !match_a_pulse)
    else $error("A pulse too long");
  a_a_flag_sticky: assert property ($fell(match_a_flag) |-> $rose(s_axi_bvalid))
    else $error("A flag lost");
  a_p_flag_sticky: assert property ($fell(match_p_flag) |-> $rose(s_axi_bvalid))
    else $error("period flag lost");
  a_period_spacing: assert property (match_p_pulse |-> p_gap_q >= 11'd127)
    else $error("period event too early");

  // Main scenarios.
  cover property (match_a_pulse);
  cover property (match_p_pulse);
  cover property ($fell(match_a_flag));
endmodule

bind compact_timer compact_timer_asserts u_chk (.*);

// >>> tb/ext_count_src.sv
/*
  Model of the external count source that drives the timer's count pin.
  Assumes the caller runs on ref_clk; the pin idles low between events.
*/
`timescale 1ns/1ps

module ext_count_src (
  input wire logic ref_clk,
  output logic     pin
);
  // Idle low.
  initial pin = 1'b0;

  // Each event: hold clocks high, then at least hold + 1 clocks low.
  task automatic pulses(input int n, input int hold);
    repeat (n)
    begin
      @(posedge ref_clk);
      pin <= 1'b1;
      repeat (hold) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (hold) @(posedge ref_clk);
    end
  endtask
endmodule

// >>> tb/compact_timer_tb_top.sv
/*
  Self-checking bench of the compact timer.
  Assumes the timer, its header and the source model.
*/
`timescale 1ns/1ps
`include "compact_timer_regs.svh"

module compact_timer_tb_top;
  // Inputs, named as the ports.
  logic        ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, high_clk_tick, sub_clk_tick;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  // Outputs and the source pin.
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        ext_count_clock_pin, timer_output_pin;
  logic        match_a_pulse, match_p_pulse, match_a_flag, match_p_flag;
  int          err_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  compact_timer u_dut (.*);
  ext_count_src u_src (.ref_clk(ref_clk), .pin(ext_count_clock_pin));

  // Free-running 100 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang limit; the run needs far fewer cycles.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  // One comparison.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write; each channel released when taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // One read; answer taken where rvalid is high.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Accesses that expect OKAY.
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, `CT_RESP_OKAY);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
    chk(r, `CT_RESP_OKAY);
  endtask

  // Counter read, high byte first.
  task automatic rcnt(output int v);
    logic [31:0] h, l;
    rreg(`CT_OFF_CNT_HI, h);
    rreg(`CT_OFF_CNT_LO, l);
    v = {h[1:0], l[7:0]};
  endtask

  // Edges to the next A or period event.
  task automatic wait_ev(input logic sel_p, output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while ((sel_p ? match_p_pulse : match_a_pulse) !== 1'b1 && n < 3000);
  endtask

  // Reset values and an unmapped address.
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rreg(`CT_OFF_CTRL0, d);
    chk(d, `CT_CTRL0_RST);
    rreg(`CT_OFF_CTRL1, d);
    chk(d, `CT_CTRL1_RST);
    rd(8'h1c, d, r);
    chk(d, 32'h0);
    chk(r, `CT_RESP_SLVERR);
    wr(8'h1c, 8'hff, r);
    chk(r, `CT_RESP_SLVERR);
  endtask

  // Buffered byte access of compare A.
  task automatic t_buf();
    logic [31:0] d;
    wreg(`CT_OFF_CMPA_LO, 8'h5a);
    rreg(`CT_OFF_CMPA_HI, d);
    chk(d, 32'h0);
    rreg(`CT_OFF_CMPA_LO, d);
    chk(d, 32'h0);
    wreg(`CT_OFF_CMPA_LO, 8'h5a);
    wreg(`CT_OFF_CMPA_HI, 8'h03);
    rreg(`CT_OFF_CMPA_HI, d);
    chk(d, 32'h3);
    rreg(`CT_OFF_CMPA_LO, d);
    chk(d, 32'h5a);
  endtask

  // Compare output: low, high and toggle functions, clear on A.
  task automatic t_cmp();
    int n;
    wreg(`CT_OFF_CMPA_LO, 8'h64);
    wreg(`CT_OFF_CMPA_HI, 8'h00);
    for (int f = 1; f < 4; f++)
    begin
      wreg(`CT_OFF_CTRL0, 8'h00);
      wreg(`CT_OFF_CTRL1, {2'b00, 2'(f), f == 1, 3'b001});
      wreg(`CT_OFF_CTRL0, 8'h18);
      repeat (2) @(posedge ref_clk);
      chk(timer_output_pin, f == 1);
      wait_ev(1'b0, n);
      wait_ev(1'b0, n);
      chk(n, 100);
      repeat (2) @(posedge ref_clk);
      chk(timer_output_pin, f == 2);
    end
    chk(match_p_flag, 1'b0);
    chk(match_a_flag, 1'b1);
    wreg(`CT_OFF_CTRL0, 8'h00);
    wreg(`CT_OFF_STATUS, 8'h01);
    #1;
    chk(match_a_flag, 1'b0);
  endtask

  // Period match for codes 0 to 2; zero overflows.
  task automatic t_period();
    int n;
    wreg(`CT_OFF_CTRL1, 8'hc0);
    for (int c = 0; c < 3; c++)
    begin
      wreg(`CT_OFF_CTRL0, 8'h00);
      wreg(`CT_OFF_CTRL0, {5'b00011, 3'(c)});
      wait_ev(1'b1, n);
      wait_ev(1'b1, n);
      chk(n, c == 0 ? 1024 : c * 128);
    end
    chk(match_p_flag, 1'b1);
  endtask

  // Pause, stop, counter writes, restart.
  task automatic t_pause();
    int v1, v2;
    wreg(`CT_OFF_CTRL0, 8'h00);
    wreg(`CT_OFF_CTRL0, 8'h18);
    repeat (100) @(posedge ref_clk);
    wreg(`CT_OFF_CTRL0, 8'h98);
    rcnt(v1);
    repeat (20) @(posedge ref_clk);
    rcnt(v2);
    chk(v2, v1);
    wreg(`CT_OFF_CTRL0, 8'h18);
    repeat (20) @(posedge ref_clk);
    rcnt(v2);
    chk(v2 - v1 >= 20 && v2 - v1 <= 40, 1'b1);
    wreg(`CT_OFF_CTRL0, 8'h10);
    rcnt(v1);
    wreg(`CT_OFF_CNT_HI, 8'h03);
    wreg(`CT_OFF_CNT_LO, 8'h55);
    rcnt(v2);
    chk(v2, v1);
    wreg(`CT_OFF_CTRL0, 8'h18);
    wreg(`CT_OFF_CTRL0, 8'h10);
    rcnt(v2);
    chk(v2 < 8, 1'b1);
  endtask

  // The other clock sources.
  task automatic t_src();
    logic [2:0] sel [7] = '{3'h4, 3'h5, 3'h2, 3'h3, 3'h6, 3'h7, 3'h0};
    int         n   [7] = '{7, 7, 32, 64, 5, 5, 400};
    int         exp [7] = '{7, 7, 2, 1, 5, 5, 0};
    int         v;
    foreach (sel[i])
    begin
      wreg(`CT_OFF_CTRL0, 8'h00);
      wreg(`CT_OFF_CTRL0, {1'b0, sel[i], 4'h8});
      if (sel[i] >= 3'h6)
        u_src.pulses(n[i], i == 4 ? 2 : 6);
      else
      begin
        sub_clk_tick <= sel[i] >= 3'h4;
        high_clk_tick <= sel[i] == 3'h2 || sel[i] == 3'h3;
        repeat (n[i]) @(posedge ref_clk);
        sub_clk_tick <= 1'b0;
        high_clk_tick <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      rcnt(v);
      if (sel[i] == 3'h0)
        chk(v >= 100 && v <= 104, 1'b1);
      else
        chk(v, exp[i]);
    end
  endtask

  // PWM duty, inversion, fixed levels.
  task automatic t_pwm();
    logic [7:0] cfg [4] = '{8'ha8, 8'hac, 8'h88, 8'h98};
    int         hi  [4] = '{32, 96, 0, 128};
    int         h, n;
    wreg(`CT_OFF_CMPA_LO, 8'h20);
    wreg(`CT_OFF_CMPA_HI, 8'h00);
    foreach (cfg[i])
    begin
      wreg(`CT_OFF_CTRL0, 8'h00);
      wreg(`CT_OFF_CTRL1, cfg[i]);
      wreg(`CT_OFF_CTRL0, 8'h19);
      wait_ev(1'b1, n);
      h = 0;
      repeat (128)
      begin
        @(posedge ref_clk);
        h += timer_output_pin;
      end
      chk(h, hi[i]);
    end
  endtask

  // Counts, verdict, end.
  task automatic finish_test();
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {high_clk_tick, sub_clk_tick} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'h1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_buf();
    t_cmp();
    t_period();
    t_pause();
    t_src();
    t_pwm();
    finish_test();
  end
endmodule
